/* File: rtl/pmx_top.sv */
// Pin function multiplexer for the upper pads of the controller.
// Assumes peripherals and the test access controller sit beside it,
// and that all pad inputs are synchronous to core_clk.
// Contract
// - Each port pad has its own direction
// - Reset leaves port pads in port use
// - Reset leaves test pads in test use
// - Test output driven only while shifting
// - Test output changes on falling test clock
// - Mode select sampled on rising, pulled up
// - Data input sampled on rising, pulled up
// - Master-in pad: input as master, output slave
// - Slave master-in line floats when unselected
// - Master-out pad: output as master, input slave
// - Slave select is a slave-only input
// - Transmit pad shares line in single-wire mode
// - PWM pads drive output or feed capture
// - Clock pad carries the selected source
// - Fault pads feed fault inputs four to seven
`timescale 1ns/1ps
module pmx_top
  import pmx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`PMX_NPAD-1:0] pad_in,
  output logic [`PMX_NPAD-1:0] pad_out,
  output logic [`PMX_NPAD-1:0] pad_oe,
  output logic [`PMX_NPAD-1:0] pad_pull_up,
  input wire logic [`PMX_NPAD-1:0] sel_wr_en,
  input wire pmx_sel_t sel_wr_data,
  input wire logic [`PMX_NPAD-1:0] gpio_out,
  input wire logic [`PMX_NPAD-1:0] gpio_dir,
  output logic [`PMX_NPAD-1:0] gpio_in,
  input wire logic [3:0] i2c_drive_low,
  output logic [3:0] i2c_line_in,
  input wire logic serial1_transmit_line,
  input wire logic sci1_single_wire,
  input wire logic sci1_tx_drive,
  output logic serial1_receive_line,
  input wire logic spi1_master,
  input wire logic spi1_miso_out,
  input wire logic spi1_mosi_out,
  output logic spi1_miso_in,
  output logic spi1_mosi_in,
  output logic spi1_ss_n_in,
  input wire logic [3:0] pwm_a_out,
  input wire logic [3:0] pwm_b_out,
  input wire logic [3:0] pwm_x_out,
  input wire logic [3:0] pwm_a_cap_en,
  input wire logic [3:0] pwm_b_cap_en,
  input wire logic [3:0] pwm_x_cap_en,
  output logic [3:0] pwm_a_cap_in,
  output logic [3:0] pwm_b_cap_in,
  output logic [3:0] pwm_x_cap_in,
  output logic [7:4] pwm_fault_in,
  input wire logic [9:4] crossbar_out,
  output logic [7:2] crossbar_in,
  input wire logic [2:0] timer_out,
  input wire logic [2:0] timer_oe,
  output logic [2:0] timer_in,
  input wire logic external_watchdog_monitor_out,
  input wire logic cmp_c_out,
  input wire logic cmp_d_out,
  input wire logic [3:0] clk_src_in,
  input wire logic [1:0] clock_out_source_select,
  input wire logic jtag_tck,
  input wire logic tap_shift_state,
  input wire logic tap_tdo_data,
  output logic tap_tms,
  output logic tap_tdi,
  output logic tap_tck_rise
);
`include "pmx_regs.svh"
  // ==========================================
  // Reset release
  logic [1:0] rst_sync; // Two-stage release of rstn
  logic rst_n_sync; // Synchronised reset for the design
  // Release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync[1];

  // ==========================================
  // Helpers
  // One-hot view of a select value
  function automatic logic [7:0] pmx_decode(input pmx_sel_t s);
    pmx_decode = 8'h01 << s;
  endfunction
  // Pad of a PWM sub-module line; b picks the B line
  function automatic int pmx_pwm_pad(input int s, input logic b);
    pmx_pwm_pad = (s < 2 ? 4 + 2 * s : 6 + 2 * s) + (b ? 0 : 1);
  endfunction

  // ==========================================
  // Pad cells
  pmx_sel_t pad_sel [`PMX_NPAD]; // Current select per pad
  logic [7:0] sel_hot [`PMX_NPAD]; // Decoded select per pad
  logic [7:0] alt_o [`PMX_NPAD]; // Alternate output per code
  logic [7:0] alt_e [`PMX_NPAD]; // Alternate enable per code
  genvar gp;
  generate
    for (gp = 0; gp < `PMX_NPAD; gp = gp + 1) begin : g_pad
      pmx_pad_cell #(
        .RESET_SEL(gp >= `PMX_FIRST_TEST ? `PMX_RST_SEL_TEST : `PMX_RST_SEL_PORT)
      ) u_cell (
        .core_clk(core_clk),
        .rst_n_sync(rst_n_sync),
        .sel_wr_en(sel_wr_en[gp]),
        .sel_wr_data(sel_wr_data),
        .gpio_out(gpio_out[gp]),
        .gpio_dir(gpio_dir[gp]),
        .alt_out(alt_o[gp]),
        .alt_oe(alt_e[gp]),
        .sel(pad_sel[gp]),
        .pad_out(pad_out[gp]),
        .pad_oe(pad_oe[gp])
      );
      assign sel_hot[gp] = pmx_decode(pad_sel[gp]);
    end
  endgenerate

  // ==========================================
  // Core state
  localparam pmx_core_s CORE_RST = '{tms: 1'b1, tdi: 1'b1, i2c_in: 4'hF, rxd: 1'b1,
                                      ss_n: 1'b1, default: '0};
  pmx_core_s r; // Registered core state
  pmx_core_s next_r; // Next core state
  logic ss_selected; // External master addresses us
  logic tck_fall; // Test clock falling this cycle
  logic tck_rise; // Test clock rising this cycle
  // Slave select counts only when its pad carries it
  assign ss_selected = sel_hot[`PMX_PAD_F7][3] && !pad_in[`PMX_PAD_F7];
  assign tck_rise = jtag_tck && !r.tck_prev;
  assign tck_fall = !jtag_tck && r.tck_prev;

  // Outward alternate functions per pad and code
  always_comb begin
    for (int p = 0; p < `PMX_NPAD; p++) begin
      alt_o[p] = 8'h00;
      alt_e[p] = 8'h00;
    end
    // Open-drain I2C: pull low only, never drive high
    alt_e[`PMX_PAD_F2][1] = i2c_drive_low[3];
    alt_e[`PMX_PAD_F3][1] = i2c_drive_low[2];
    alt_e[`PMX_PAD_C15][1] = i2c_drive_low[1];
    alt_e[`PMX_PAD_C14][1] = i2c_drive_low[0];
    // Crossbar outputs
    alt_o[`PMX_PAD_F2][2] = crossbar_out[6];
    alt_o[`PMX_PAD_F3][2] = crossbar_out[7];
    alt_o[`PMX_PAD_F4][2] = crossbar_out[8];
    alt_o[`PMX_PAD_F5][2] = crossbar_out[9];
    alt_o[`PMX_PAD_C14][2] = crossbar_out[4];
    alt_o[`PMX_PAD_C15][2] = crossbar_out[5];
    alt_e[`PMX_PAD_F2][2] = 1'b1;
    alt_e[`PMX_PAD_F3][2] = 1'b1;
    alt_e[`PMX_PAD_F4][2] = 1'b1;
    alt_e[`PMX_PAD_F5][2] = 1'b1;
    alt_e[`PMX_PAD_C14][2] = 1'b1;
    alt_e[`PMX_PAD_C15][2] = 1'b1;
    // Master-in: input as master, driven as selected slave
    alt_o[`PMX_PAD_F2][3] = spi1_miso_out;
    alt_e[`PMX_PAD_F2][3] = !spi1_master && ss_selected;
    // Master-out: output as master, input as slave
    alt_o[`PMX_PAD_F3][3] = spi1_mosi_out;
    alt_e[`PMX_PAD_F3][3] = spi1_master;
    // Transmit: always out, or shared line in single-wire
    alt_o[`PMX_PAD_F4][1] = serial1_transmit_line;
    alt_e[`PMX_PAD_F4][1] = sci1_single_wire ? sci1_tx_drive : 1'b1;
    // X lines of PWM; capture turns the pad round
    alt_o[`PMX_PAD_F4][3] = pwm_x_out[0];
    alt_e[`PMX_PAD_F4][3] = !pwm_x_cap_en[0];
    alt_o[`PMX_PAD_F5][3] = pwm_x_out[1];
    alt_e[`PMX_PAD_F5][3] = !pwm_x_cap_en[1];
    alt_o[`PMX_PAD_F6][2] = pwm_x_out[3];
    alt_e[`PMX_PAD_F6][2] = !pwm_x_cap_en[3];
    // A and B lines of every sub-module
    for (int s = 0; s < 4; s++) begin
      alt_o[pmx_pwm_pad(s, 1'b1)][1] = pwm_b_out[s];
      alt_e[pmx_pwm_pad(s, 1'b1)][1] = !pwm_b_cap_en[s];
      alt_o[pmx_pwm_pad(s, 1'b0)][1] = pwm_a_out[s];
      alt_e[pmx_pwm_pad(s, 1'b0)][1] = !pwm_a_cap_en[s];
    end
    // Timer channels and other on-chip outputs
    alt_o[`PMX_PAD_C13][1] = timer_out[0];
    alt_e[`PMX_PAD_C13][1] = timer_oe[0];
    alt_o[`PMX_PAD_F6][1] = timer_out[1];
    alt_e[`PMX_PAD_F6][1] = timer_oe[1];
    alt_o[`PMX_PAD_F7][1] = timer_out[2];
    alt_e[`PMX_PAD_F7][1] = timer_oe[2];
    alt_o[`PMX_PAD_C13][3] = external_watchdog_monitor_out;
    alt_e[`PMX_PAD_C13][3] = 1'b1;
    alt_o[`PMX_PAD_F1][3] = cmp_d_out;
    alt_e[`PMX_PAD_F1][3] = 1'b1;
    alt_o[`PMX_PAD_F7][2] = cmp_c_out;
    alt_e[`PMX_PAD_F7][2] = 1'b1;
    // Buffered clock from the chosen source
    alt_o[`PMX_PAD_F1][1] = clk_src_in[clock_out_source_select];
    alt_e[`PMX_PAD_F1][1] = 1'b1;
    // Test output floats outside the shift states
    alt_o[`PMX_PAD_TDO][1] = r.tdo;
    alt_e[`PMX_PAD_TDO][1] = tap_shift_state;
  end

  // Inward routing and test clock sampling
  always_comb begin
    next_r = r;
    next_r.tck_prev = jtag_tck;
    next_r.tck_rise = tck_rise;
    next_r.gpio_in = pad_in;
    // Test output moves only on a falling test clock
    if (tck_fall) begin
      next_r.tdo = tap_tdo_data;
    end
    // Rising test clock samples mode select and data
    if (tck_rise) begin
      next_r.tms = sel_hot[`PMX_PAD_TMS][1] ? pad_in[`PMX_PAD_TMS] : 1'b1;
      next_r.tdi = sel_hot[`PMX_PAD_TDI][1] ? pad_in[`PMX_PAD_TDI] : 1'b1;
    end
    // Idle-high lines read high when not routed
    next_r.i2c_in[3] = sel_hot[`PMX_PAD_F2][1] ? pad_in[`PMX_PAD_F2] : 1'b1;
    next_r.i2c_in[2] = sel_hot[`PMX_PAD_F3][1] ? pad_in[`PMX_PAD_F3] : 1'b1;
    next_r.i2c_in[1] = sel_hot[`PMX_PAD_C15][1] ? pad_in[`PMX_PAD_C15] : 1'b1;
    next_r.i2c_in[0] = sel_hot[`PMX_PAD_C14][1] ? pad_in[`PMX_PAD_C14] : 1'b1;
    // Single-wire receive listens on the transmit pad
    if (sci1_single_wire) begin
      next_r.rxd = sel_hot[`PMX_PAD_F4][1] ? pad_in[`PMX_PAD_F4] : 1'b1;
    end else begin
      next_r.rxd = sel_hot[`PMX_PAD_F5][1] ? pad_in[`PMX_PAD_F5] : 1'b1;
    end
    // SPI inputs by role
    next_r.miso = sel_hot[`PMX_PAD_F2][3] && spi1_master && pad_in[`PMX_PAD_F2];
    next_r.mosi = sel_hot[`PMX_PAD_F3][3] && !spi1_master && pad_in[`PMX_PAD_F3];
    next_r.ss_n = spi1_master || !ss_selected;
    // Capture inputs
    for (int s = 0; s < 4; s++) begin
      next_r.cap_b[s] = sel_hot[pmx_pwm_pad(s, 1'b1)][1] && pad_in[pmx_pwm_pad(s, 1'b1)];
      next_r.cap_a[s] = sel_hot[pmx_pwm_pad(s, 1'b0)][1] && pad_in[pmx_pwm_pad(s, 1'b0)];
    end
    next_r.cap_x[0] = sel_hot[`PMX_PAD_F4][3] && pad_in[`PMX_PAD_F4];
    next_r.cap_x[1] = sel_hot[`PMX_PAD_F5][3] && pad_in[`PMX_PAD_F5];
    next_r.cap_x[2] = 1'b0; // Sub-module 2 has no X pad here
    next_r.cap_x[3] = sel_hot[`PMX_PAD_F6][2] && pad_in[`PMX_PAD_F6];
    // Fault levels, inactive low when unrouted
    next_r.fault[0] = sel_hot[`PMX_PAD_C14][3] && pad_in[`PMX_PAD_C14];
    next_r.fault[1] = sel_hot[`PMX_PAD_C15][3] && pad_in[`PMX_PAD_C15];
    next_r.fault[2] = sel_hot[`PMX_PAD_F4][4] && pad_in[`PMX_PAD_F4];
    next_r.fault[3] = sel_hot[`PMX_PAD_F5][4] && pad_in[`PMX_PAD_F5];
    // Crossbar inputs; two pads may share one input, so OR them
    next_r.xbar[0] = (sel_hot[10][2] && pad_in[10]) || (sel_hot[`PMX_PAD_F6][3] && pad_in[`PMX_PAD_F6]);
    next_r.xbar[1] = (sel_hot[11][2] && pad_in[11]) || (sel_hot[`PMX_PAD_F7][4] && pad_in[`PMX_PAD_F7]);
    next_r.xbar[2] = sel_hot[12][2] && pad_in[12];
    next_r.xbar[3] = sel_hot[13][2] && pad_in[13];
    next_r.xbar[4] = sel_hot[`PMX_PAD_C13][2] && pad_in[`PMX_PAD_C13];
    next_r.xbar[5] = sel_hot[`PMX_PAD_F1][2] && pad_in[`PMX_PAD_F1];
    // Timer channel inputs
    next_r.timer[0] = sel_hot[`PMX_PAD_C13][1] && pad_in[`PMX_PAD_C13];
    next_r.timer[1] = sel_hot[`PMX_PAD_F6][1] && pad_in[`PMX_PAD_F6];
    next_r.timer[2] = sel_hot[`PMX_PAD_F7][1] && pad_in[`PMX_PAD_F7];
  end

  // Core register
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      r <= CORE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // Outputs
  // Pull-ups on the test inputs while in test use
  always_comb begin
    pad_pull_up = '0;
    pad_pull_up[`PMX_PAD_TMS] = sel_hot[`PMX_PAD_TMS][1];
    pad_pull_up[`PMX_PAD_TDI] = sel_hot[`PMX_PAD_TDI][1];
  end
  assign gpio_in = r.gpio_in;
  assign i2c_line_in = r.i2c_in;
  assign serial1_receive_line = r.rxd;
  assign spi1_miso_in = r.miso;
  assign spi1_mosi_in = r.mosi;
  assign spi1_ss_n_in = r.ss_n;
  assign pwm_a_cap_in = r.cap_a;
  assign pwm_b_cap_in = r.cap_b;
  assign pwm_x_cap_in = r.cap_x;
  assign pwm_fault_in = r.fault;
  assign crossbar_in = r.xbar;
  assign timer_in = r.timer;
  assign tap_tms = r.tms;
  assign tap_tdi = r.tdi;
  assign tap_tck_rise = r.tck_rise;

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_sync);
  sequence test_edge_s;
    jtag_tck && !r.tck_prev;
  endsequence
  reset_defaults_a: assert property ($rose(rst_n_sync) |-> pad_sel[0] == `PMX_SEL_PORT &&
    pad_sel[`PMX_PAD_TDO] == `PMX_SEL_ALT1 && pad_sel[`PMX_PAD_TDI] == `PMX_SEL_ALT1)
    else $error("Pad selects wrong after reset");
  tdo_drive_a: assert property (sel_hot[`PMX_PAD_TDO][1] && $past(sel_hot[`PMX_PAD_TDO][1])
    |-> pad_oe[`PMX_PAD_TDO] == $past(tap_shift_state)) else $error("Test output drive wrong");
  tdo_edge_a: assert property ($changed(r.tdo) |-> $past(tck_fall))
    else $error("Test output moved off a falling edge");
  tms_sample_a: assert property (test_edge_s ##0 sel_hot[`PMX_PAD_TMS][1]
    |=> tap_tms == $past(pad_in[`PMX_PAD_TMS]) && tap_tck_rise) else $error("Mode select not sampled");
  tdi_sample_a: assert property (test_edge_s ##0 sel_hot[`PMX_PAD_TDI][1]
    |=> tap_tdi == $past(pad_in[`PMX_PAD_TDI])) else $error("Data input not sampled");
  miso_master_a: assert property (sel_hot[`PMX_PAD_F2][3] && spi1_master
    |=> !pad_oe[`PMX_PAD_F2]) else $error("Master-in driven as master");
  miso_float_a: assert property (sel_hot[`PMX_PAD_F2][3] && !ss_selected
    |=> !pad_oe[`PMX_PAD_F2]) else $error("Master-in driven while unselected");
  mosi_dir_a: assert property (sel_hot[`PMX_PAD_F3][3]
    |=> pad_oe[`PMX_PAD_F3] == $past(spi1_master)) else $error("Master-out direction wrong");
  ss_route_a: assert property (spi1_master |=> spi1_ss_n_in)
    else $error("Slave select seen as master");
  txd_drive_a: assert property (sel_hot[`PMX_PAD_F4][1] && !sci1_single_wire
    |=> pad_oe[`PMX_PAD_F4] && pad_out[`PMX_PAD_F4] == $past(serial1_transmit_line))
    else $error("Transmit pad not driving");
  pwm_capture_a: assert property (sel_hot[5][1] && pwm_a_cap_en[0]
    |=> !pad_oe[5] && pwm_a_cap_in[0] == $past(pad_in[5])) else $error("Capture pad wrong");
  clock_out_a: assert property (sel_hot[`PMX_PAD_F1][1]
    |=> pad_out[`PMX_PAD_F1] == $past(clk_src_in[clock_out_source_select])) else $error("Clock pad wrong");
  fault_route_a: assert property (sel_hot[`PMX_PAD_C14][3]
    |=> pwm_fault_in[4] == $past(pad_in[`PMX_PAD_C14])) else $error("Fault input not routed");
  port_dir_a: assert property (pad_sel[4] == `PMX_SEL_PORT ##1 pad_sel[4] == `PMX_SEL_PORT
    |-> pad_oe[4] == $past(gpio_dir[4])) else $error("Port direction not applied");
endmodule

/* File: rtl/pmx_regs.svh */
// Constants of the pin function multiplexer.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH
// ==========================================
// Pad count and select field
`define PMX_NPAD 21
`define PMX_SEL_W 3
`define PMX_SEL_PORT 3'h0
`define PMX_SEL_ALT1 3'h1
`define PMX_SEL_ALT2 3'h2
`define PMX_SEL_ALT3 3'h3
`define PMX_SEL_ALT4 3'h4
// ==========================================
// Reset selections
`define PMX_RST_SEL_PORT 3'h0
`define PMX_RST_SEL_TEST 3'h1
`define PMX_FIRST_TEST 18
// ==========================================
// Pad indices
`define PMX_PAD_F2 0
`define PMX_PAD_F3 1
`define PMX_PAD_F4 2
`define PMX_PAD_F5 3
`define PMX_PAD_C13 8
`define PMX_PAD_F1 9
`define PMX_PAD_C14 14
`define PMX_PAD_C15 15
`define PMX_PAD_F6 16
`define PMX_PAD_F7 17
`define PMX_PAD_TDO 18
`define PMX_PAD_TMS 19
`define PMX_PAD_TDI 20
`endif

/* File: rtl/pmx_pkg.sv */
// Types of the pin function multiplexer.
// Assumes pmx_regs.svh on the include path.
package pmx_pkg;
`include "pmx_regs.svh"
  // Function select of one pad
  typedef logic [`PMX_SEL_W-1:0] pmx_sel_t;
  // State of one pad cell
  typedef struct packed {
    pmx_sel_t sel;
    logic pad_out;
    logic pad_oe;
  } pmx_cell_s;
  // State of the mux core
  typedef struct packed {
    logic tck_prev;
    logic tck_rise;
    logic tdo;
    logic tms;
    logic tdi;
    logic [`PMX_NPAD-1:0] gpio_in;
    logic [3:0] i2c_in;
    logic rxd;
    logic miso;
    logic mosi;
    logic ss_n;
    logic [3:0] cap_a;
    logic [3:0] cap_b;
    logic [3:0] cap_x;
    logic [3:0] fault;
    logic [5:0] xbar;
    logic [2:0] timer;
  } pmx_core_s;
endpackage

/* File: rtl/pmx_pad_cell.sv */
// One pad cell: its select register and the final output mux.
// Assumes a clock and a synchronised active-low reset from the top.
`timescale 1ns/1ps
module pmx_pad_cell
  import pmx_pkg::*;
#(
  parameter pmx_sel_t RESET_SEL = `PMX_RST_SEL_PORT
) (
  input wire logic core_clk,
  input wire logic rst_n_sync,
  input wire logic sel_wr_en,
  input wire pmx_sel_t sel_wr_data,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  output pmx_sel_t sel,
  output logic pad_out,
  output logic pad_oe
);
  // ==========================================
  // State
  pmx_cell_s r; // Registered cell state
  pmx_cell_s next_r; // Next cell state

  // Select update and pad mux
  always_comb begin
    next_r = r;
    if (sel_wr_en) begin // Software selects a function
      next_r.sel = sel_wr_data;
    end
    if (r.sel == `PMX_SEL_PORT) begin // Plain port, own direction
      next_r.pad_out = gpio_out;
      next_r.pad_oe = gpio_dir;
    end else begin // Alternate function owns the pad
      next_r.pad_out = alt_out[r.sel];
      next_r.pad_oe = alt_oe[r.sel];
    end
  end

  // Register; the reset select picks port or test use
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      r <= '{sel: RESET_SEL, pad_out: 1'b0, pad_oe: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign sel = r.sel;
  assign pad_out = r.pad_out;
  assign pad_oe = r.pad_oe;
endmodule

/* File: test/pmx_board_model.sv */
// Board side of the pads: device drive, external drivers and pull-ups.
// Assumes the bench sets the external drive pattern on core_clk edges.
`timescale 1ns/1ps
module pmx_board_model (
  input wire logic core_clk,
  input wire logic [20:0] pad_out,
  input wire logic [20:0] pad_oe,
  input wire logic [20:0] pad_pull_up,
  input wire logic [20:0] ext_en,
  input wire logic [20:0] ext_val,
  output logic [20:0] pad_in
);
  // ==========================================
  // Floating level
  logic flip = 1'b0; // Toggles so a released line never keeps its last value
  always @(posedge core_clk) begin
    flip <= ~flip;
  end
  // ==========================================
  // Pad resolution
  // Device drive wins, so a clash shows as a bad received value
  always_comb begin
    for (int i = 0; i < 21; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i]; // Held across the sampling edge
      end else if (pad_pull_up[i]) begin
        pad_in[i] = 1'b1; // Weak pull-up only
      end else begin
        pad_in[i] = flip ^ i[0]; // Undriven pad wanders
      end
    end
  end
endmodule

/* File: test/test_pin_function_multiplexer.sv */
// Self-checking bench of the pin function multiplexer.
// Assumes pmx_regs.svh on the include path and the board model beside it.
`timescale 1ns/1ps
`include "pmx_regs.svh"
module test_pin_function_multiplexer import pmx_pkg::*;;
  // ==========================================
  // Signals
  logic core_clk, rstn, jtag_tck, tap_shift_state, tap_tdo_data, tap_tms, tap_tdi, tap_tck_rise;
  logic [20:0] pad_in, pad_out, pad_oe, pad_pull_up, sel_wr_en, gpio_out, gpio_dir, gpio_in, ext_en, ext_val;
  pmx_sel_t sel_wr_data; // Function code for writes
  logic [3:0] i2c_drive_low, i2c_line_in, pwm_a_out, pwm_b_out, pwm_x_out, clk_src_in;
  logic [3:0] pwm_a_cap_en, pwm_b_cap_en, pwm_x_cap_en, pwm_a_cap_in, pwm_b_cap_in, pwm_x_cap_in;
  logic [7:4] pwm_fault_in;
  logic [9:4] crossbar_out;
  logic [7:2] crossbar_in;
  logic [2:0] timer_out, timer_oe, timer_in;
  logic [1:0] clock_out_source_select;
  logic serial1_transmit_line, sci1_single_wire, sci1_tx_drive, serial1_receive_line, spi1_master;
  logic spi1_miso_out, spi1_mosi_out, spi1_miso_in, spi1_mosi_in, spi1_ss_n_in;
  logic external_watchdog_monitor_out, cmp_c_out, cmp_d_out;
  int n_errors, check_count; // Mismatches and comparisons
  // ==========================================
  // Design and board
  pmx_top uut (.core_clk(core_clk), .rstn(rstn), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .sel_wr_en(sel_wr_en), .sel_wr_data(sel_wr_data), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .gpio_in(gpio_in), .i2c_drive_low(i2c_drive_low), .i2c_line_in(i2c_line_in),
    .serial1_transmit_line(serial1_transmit_line), .sci1_single_wire(sci1_single_wire),
    .sci1_tx_drive(sci1_tx_drive), .serial1_receive_line(serial1_receive_line), .spi1_master(spi1_master),
    .spi1_miso_out(spi1_miso_out), .spi1_mosi_out(spi1_mosi_out), .spi1_miso_in(spi1_miso_in),
    .spi1_mosi_in(spi1_mosi_in), .spi1_ss_n_in(spi1_ss_n_in), .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out),
    .pwm_x_out(pwm_x_out), .pwm_a_cap_en(pwm_a_cap_en), .pwm_b_cap_en(pwm_b_cap_en),
    .pwm_x_cap_en(pwm_x_cap_en), .pwm_a_cap_in(pwm_a_cap_in), .pwm_b_cap_in(pwm_b_cap_in),
    .pwm_x_cap_in(pwm_x_cap_in), .pwm_fault_in(pwm_fault_in), .crossbar_out(crossbar_out),
    .crossbar_in(crossbar_in), .timer_out(timer_out), .timer_oe(timer_oe), .timer_in(timer_in),
    .external_watchdog_monitor_out(external_watchdog_monitor_out), .cmp_c_out(cmp_c_out),
    .cmp_d_out(cmp_d_out), .clk_src_in(clk_src_in), .clock_out_source_select(clock_out_source_select),
    .jtag_tck(jtag_tck), .tap_shift_state(tap_shift_state), .tap_tdo_data(tap_tdo_data),
    .tap_tms(tap_tms), .tap_tdi(tap_tdi), .tap_tck_rise(tap_tck_rise));
  pmx_board_model board (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  // ==========================================
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Whole run is under two hundred cycles; this is ample margin
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end
  // ==========================================
  // Shared helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Registered paths need at most three edges; sample mid-cycle
  task settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task set_sel(input int p, input pmx_sel_t code);
    @(posedge core_clk);
    sel_wr_en <= 21'h000001 << p;
    sel_wr_data <= code;
    @(posedge core_clk);
    sel_wr_en <= 21'h000000;
  endtask
  // Moves the test clock and counts rise pulses seen after it
  task tck(input logic v);
    int np;
    @(posedge core_clk);
    jtag_tck <= v;
    np = 0;
    repeat (4) begin
      @(negedge core_clk);
      np += (tap_tck_rise === 1'b1);
    end
    chk(np, v);
  endtask
  task stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_reset();
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(pad_oe, 21'h000000);
    chk(pad_pull_up, 21'h180000);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    settle(4);
    chk(pad_oe, {3'h0, 18'h3FFFF});
    chk(pad_out[17:0], 18'h15555);
    chk({tap_tms, tap_tdi}, 2'h3);
  endtask
  // Both direction patterns, each port pad in once and out once
  task t_gpio();
    logic [20:0] d;
    for (int k = 0; k < 2; k++) begin
      d = k ? 21'h00F0F0 : 21'h030F0F;
      @(posedge core_clk);
      gpio_dir <= d;
      ext_en <= d ^ 21'h03FFFF;
      ext_val <= 21'h02A5C3;
      settle(3);
      chk(pad_oe[17:0], d[17:0]);
      chk(pad_out & d, 21'h155555 & d);
      chk(gpio_in & ~d & 21'h03FFFF, 21'h02A5C3 & ~d & 21'h03FFFF);
    end
  endtask
  task t_jtag();
    @(posedge core_clk);
    tap_tdo_data <= 1'b1;
    ext_en <= 21'h180000;
    ext_val <= 21'h000000;
    tck(1'b1);
    chk({pad_oe[18], pad_out[18], tap_tms, tap_tdi}, 4'h0);
    @(posedge core_clk);
    ext_val <= 21'h180000;
    tap_shift_state <= 1'b1;
    settle(3);
    chk({pad_oe[18], tap_tms, tap_tdi}, 3'h4);
    tck(1'b0);
    chk(pad_out[18], 1'b1);
    @(posedge core_clk);
    tap_tdo_data <= 1'b0;
    ext_en <= 21'h000000;
    tck(1'b1);
    chk({pad_out[18], tap_tms, tap_tdi}, 3'h7);
    tck(1'b0);
    chk(pad_out[18], 1'b0);
    @(posedge core_clk);
    tap_shift_state <= 1'b0;
    settle(3);
    chk(pad_oe[18], 1'b0);
  endtask
  task t_spi();
    set_sel(0, 3'h3);
    set_sel(1, 3'h3);
    set_sel(17, 3'h3);
    @(posedge core_clk);
    spi1_master <= 1'b1;
    spi1_mosi_out <= 1'b1;
    ext_en <= 21'h000001;
    ext_val <= 21'h000001;
    settle(3);
    chk({pad_oe[0], pad_oe[1], pad_out[1], spi1_ss_n_in, spi1_miso_in}, 5'h0F);
    @(posedge core_clk);
    spi1_master <= 1'b0;
    ext_en <= 21'h020002;
    ext_val <= 21'h020002;
    settle(3);
    chk({pad_oe[0], pad_oe[1], spi1_ss_n_in, spi1_mosi_in}, 4'h3);
    @(posedge core_clk);
    ext_val <= 21'h000000; // External master selects this device
    spi1_miso_out <= 1'b1;
    settle(3);
    chk({pad_oe[0], pad_out[0], spi1_ss_n_in, spi1_mosi_in}, 4'hC);
  endtask
  task t_serial();
    set_sel(2, 3'h1);
    set_sel(3, 3'h1);
    @(posedge core_clk);
    serial1_transmit_line <= 1'b1;
    ext_en <= 21'h000008;
    settle(3);
    chk({pad_oe[2], pad_out[2], serial1_receive_line}, 3'h6);
    @(posedge core_clk);
    sci1_single_wire <= 1'b1;
    ext_en <= 21'h000004;
    settle(3);
    chk({pad_oe[2], serial1_receive_line}, 2'h0);
    @(posedge core_clk);
    sci1_tx_drive <= 1'b1;
    serial1_transmit_line <= 1'b0;
    settle(3);
    chk({pad_oe[2], pad_out[2]}, 2'h2);
    @(posedge core_clk);
    sci1_single_wire <= 1'b0;
  endtask
  task t_pwm();
    for (int p = 4; p < 8; p++) begin
      set_sel(p, 3'h1);
    end
    @(posedge core_clk);
    pwm_a_out <= 4'h2;
    pwm_b_out <= 4'h1;
    ext_en <= 21'h000020;
    settle(3);
    chk({pad_oe[7:4], pad_out[7:4]}, 8'hF9);
    @(posedge core_clk);
    pwm_a_cap_en <= 4'h1;
    settle(3);
    chk({pad_oe[5], pwm_a_cap_in[0]}, 2'h0);
    @(posedge core_clk);
    ext_val <= 21'h000020;
    settle(3);
    chk({pad_oe[5], pwm_a_cap_in[0], pwm_b_cap_in}, 6'h11);
  endtask
  task t_clk();
    set_sel(9, 3'h1);
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      clock_out_source_select <= 2'(s);
      settle(3);
      chk({pad_oe[9], pad_out[9]}, {1'b1, 1'(4'h6 >> s)});
    end
  endtask
  task t_fault();
    set_sel(14, 3'h3);
    set_sel(15, 3'h3);
    set_sel(2, 3'h4);
    set_sel(3, 3'h4);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      ext_en <= 21'h00C00C;
      ext_val <= k ? 21'h008008 : 21'h004004;
      settle(3);
      chk({pwm_fault_in, pad_oe[15:14], pad_oe[3:2]}, {(k ? 4'hA : 4'h5), 4'h0});
    end
  endtask
  // Open-drain pull, timer and crossbar inputs
  task t_misc();
    set_sel(14, 3'h1);
    set_sel(15, 3'h1);
    set_sel(8, 3'h1);
    set_sel(10, 3'h2);
    @(posedge core_clk);
    i2c_drive_low <= 4'h1;
    ext_en <= 21'h008500;
    ext_val <= 21'h000500;
    settle(3);
    chk({i2c_line_in, pad_oe[15:14], pad_out[14], timer_in, crossbar_in}, 16'hC441);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rstn, jtag_tck, tap_shift_state, tap_tdo_data, serial1_transmit_line, sci1_single_wire} = '0;
    {sci1_tx_drive, spi1_master, spi1_miso_out, spi1_mosi_out, external_watchdog_monitor_out} = '0;
    {cmp_c_out, cmp_d_out, i2c_drive_low, pwm_a_out, pwm_b_out, pwm_x_out, crossbar_out} = '0;
    {pwm_a_cap_en, pwm_b_cap_en, pwm_x_cap_en, timer_out, timer_oe, clock_out_source_select} = '0;
    {sel_wr_en, sel_wr_data, ext_en, ext_val} = '0;
    gpio_dir = 21'h1FFFFF;
    gpio_out = 21'h155555;
    clk_src_in = 4'h6;
    n_errors = 0;
    check_count = 0;
    t_reset();
    t_gpio();
    t_jtag();
    t_spi();
    t_serial();
    t_pwm();
    t_clk();
    t_fault();
    t_misc();
    stop_test();
  end
endmodule
